// ### include/delay_manager_map.vh
// register map, field positions, reset values and timing counts of the delay manager
// Function
// - eight-bit timer clears, or loads median, with prescaler ratio changes
// - demag, two zero-cross captures, multiplier, compare
// - mode bit: 0 switched, 1 autoswitched
// - autoswitched mode commutates from rotor position
// - soft enable: compare match raises simulated commutation
// - no soft compare before compare register written
// - nonzero tacho select means speed measurement only
// - switched: match commutates and clears timer
// - commutation loads preloads, sets flag, masked irq
// - divider ratio writable only while clock disabled
// - switched: ratio requests applied at next commutation
// - ratio update shifts demag and captures (a zero-cross speed-up captures instead), switched compare too; timer clears, or loads median on auto_up
// - both ratio requests written together are ignored
// - switched: zero-cross and demag leave timer alone
// - switched overflow wraps; flag only tacho 00
// - autoswitched: prescaler follows latest zero-cross capture
// - autoswitched: zero-cross captures timer, shifts prior, clears timer
// - autoswitched: compare equals weight times selected capture over 256
`ifndef DELAY_MANAGER_MAP_VH
`define DELAY_MANAGER_MAP_VH
`define ADDR_TIMER 12'h000
`define ADDR_COMPARE 12'h004
`define ADDR_DEMAG 12'h008
`define ADDR_ZLATEST 12'h00C
`define ADDR_ZPRIOR 12'h010
`define ADDR_WEIGHT 12'h014
`define ADDR_DIVIDER 12'h018
`define ADDR_CTRL 12'h01C
`define ADDR_PARAM 12'h020
`define ADDR_FLAGS 12'h024
// control_reg_c bits
`define CTRL_CKE 0
`define CTRL_SWA 1
`define CTRL_SC 2
`define CTRL_DCB 3
// event_flag_register bits
`define FLG_CI 0
`define FLG_CIM 1
`define FLG_RPI 2
`define FLG_RMI 3
`define FLG_OI 4
// param_register field
`define PAR_TES_LSB 0
`define RST_BYTE 8'h00
`define TIMER_MEDIAN 8'h80
`define TIMER_MAX 8'hFF
`define TIMER_SPEEDUP 8'h55
`define RATIO_MAX 4'hF
`define RATIO_MIN 4'h0
`endif

// ### verilog/delay_manager.v
// delay manager: shifting timer, captures, multiplier and commutation logic
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "delay_manager_map.vh"
module delay_manager #(
	parameter RATIO_W = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire zero_cross_in,
	input wire demag_in,
	output reg commutation_event,
	output reg preload_strobe,
	output wire commutation_irq,
	output wire speed_mode
);

////////////////////////////////////////////////////////////////////////////
// event inputs come from another block's pins: two-stage synchronisers
// edge detectors reset low, the idle level of both event pins
reg [1:0] zc_sync_q;
reg [1:0] dm_sync_q;
reg zc_prev_q;
reg dm_prev_q;
wire zc_evt;
wire dm_evt;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		zc_sync_q <= 2'h0;
		dm_sync_q <= 2'h0;
		zc_prev_q <= 1'b0;
		dm_prev_q <= 1'b0;
	end else begin
		zc_sync_q <= {zc_sync_q[0], zero_cross_in};
		dm_sync_q <= {dm_sync_q[0], demag_in};
		zc_prev_q <= zc_sync_q[1];
		dm_prev_q <= dm_sync_q[1];
	end
end

assign zc_evt = zc_sync_q[1] & ~zc_prev_q;
assign dm_evt = dm_sync_q[1] & ~dm_prev_q;

////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] delay_timer_q;
reg [7:0] commutation_compare_q;
reg [7:0] demag_register_q;
reg [7:0] zero_cross_latest_q;
reg [7:0] zero_cross_prior_q;
reg [7:0] phase_weight_q;
reg [RATIO_W-1:0] divider_ratio_q;
reg [3:0] control_reg_c_q;
reg [1:0] tacho_edge_select_q;
reg commutation_flag_q;
reg commutation_irq_mask_q;
reg ratio_up_request_q;
reg ratio_down_request_q;
reg overflow_flag_q;
reg compare_armed_q;
reg mul_pending_q;
reg step_done_q;
reg [15:0] presc_cnt_q;

wire cke = control_reg_c_q[`CTRL_CKE];
wire auto_commutation_mode = control_reg_c_q[`CTRL_SWA];
wire sc = control_reg_c_q[`CTRL_SC];
wire dcb = control_reg_c_q[`CTRL_DCB];
wire six_step = (tacho_edge_select_q == 2'h0);

assign speed_mode = ~six_step;
assign pready = 1'b1;
assign pslverr = 1'b0;
assign commutation_irq = commutation_flag_q & commutation_irq_mask_q;

wire wr = psel & penable & pwrite;
wire wr_timer = wr & (paddr == `ADDR_TIMER);
wire wr_cmp = wr & (paddr == `ADDR_COMPARE);
wire wr_demag = wr & (paddr == `ADDR_DEMAG);
wire wr_zl = wr & (paddr == `ADDR_ZLATEST);
wire wr_zp = wr & (paddr == `ADDR_ZPRIOR);
wire wr_flags = wr & (paddr == `ADDR_FLAGS);

////////////////////////////////////////////////////////////////////////////
// prescaler: one tick every 2^ratio clocks
wire [15:0] presc_top = (16'h0001 << divider_ratio_q) - 16'h0001;
wire tick = cke & (presc_cnt_q >= presc_top);

// product of weight and selected capture, top byte kept
wire [7:0] mul_src = dcb ? zero_cross_latest_q : zero_cross_prior_q;
wire [15:0] product = phase_weight_q * mul_src;
wire [7:0] mul_res = product[15:8];

// commutation sources
wire soft_match = sc & compare_armed_q &
	(delay_timer_q == commutation_compare_q);
// a zero compare in switched mode would commutate on every clock
wire sw_match = ~auto_commutation_mode & ~sc & (delay_timer_q == commutation_compare_q);
// timer runs on past the compare value: one hardware commutation a step
wire hw_match = auto_commutation_mode & ~sc & ~mul_pending_q & ~step_done_q &
	(zero_cross_latest_q != 8'h00) &
	(delay_timer_q >= commutation_compare_q);
wire commute = cke & six_step & (soft_match | sw_match | hw_match);

// prescaler updates
// at full scale auto mode slows the timer instead of wrapping while the ratio is below RATIO_MAX
wire at_max = tick & (delay_timer_q == `TIMER_MAX);
wire auto_mode = cke & auto_commutation_mode & six_step;
wire auto_up = auto_mode & at_max & (divider_ratio_q != `RATIO_MAX);
wire auto_dn = auto_mode & zc_evt & (delay_timer_q < `TIMER_SPEEDUP) &
	(divider_ratio_q != `RATIO_MIN);
wire sw_up = commute & ~auto_commutation_mode & ratio_up_request_q &
	(divider_ratio_q != `RATIO_MAX);
wire sw_dn = commute & ~auto_commutation_mode & ratio_down_request_q &
	(divider_ratio_q != `RATIO_MIN);
wire shr = auto_up | sw_up;
wire shl = auto_dn | sw_dn;
wire zc_hw = auto_commutation_mode & zc_evt;

////////////////////////////////////////////////////////////////////////////
// timer, captures and compare
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		delay_timer_q <= `RST_BYTE;
		commutation_compare_q <= `RST_BYTE;
		zero_cross_latest_q <= `RST_BYTE;
		zero_cross_prior_q <= `RST_BYTE;
		compare_armed_q <= 1'b0;
		mul_pending_q <= 1'b0;
		step_done_q <= 1'b0;
	end else begin
		// timer: a write while stopped wins, so start-up values load cleanly
		if (!cke && wr_timer)
			delay_timer_q <= pwdata[7:0];
		else if (zc_hw || (commute && !auto_commutation_mode))
			delay_timer_q <= `RST_BYTE;
		else if (auto_up)
			delay_timer_q <= `TIMER_MEDIAN;
		else if (sw_up)
			delay_timer_q <= delay_timer_q >> 1;
		else if (shl)
			delay_timer_q <= delay_timer_q << 1;
		else if (tick)
			delay_timer_q <= delay_timer_q + 8'h01;
		// zero-cross captures
		if (wr_zl)
			zero_cross_latest_q <= pwdata[7:0];
		else if (zc_hw) begin
			zero_cross_latest_q <= delay_timer_q;
			zero_cross_prior_q <= zero_cross_latest_q;
		end else if (shr) begin
			zero_cross_latest_q <= zero_cross_latest_q >> 1;
			zero_cross_prior_q <= zero_cross_prior_q >> 1;
		end else if (shl) begin
			zero_cross_latest_q <= zero_cross_latest_q << 1;
			zero_cross_prior_q <= zero_cross_prior_q << 1;
		end
		if (wr_zp && !zc_hw)
			zero_cross_prior_q <= pwdata[7:0];
		// one hardware commutation per step; a new capture starts the next
		if (zc_hw || !auto_commutation_mode || sc)
			step_done_q <= 1'b0;
		else if (hw_match)
			step_done_q <= 1'b1;
		// compare register stays writable in both modes
		if (wr_cmp) begin
			commutation_compare_q <= pwdata[7:0];
			compare_armed_q <= 1'b1;
		end else begin
			if (soft_match)
				compare_armed_q <= 1'b0;
			if (!sc)
				compare_armed_q <= 1'b0;
			// the product is taken a cycle after the capture or shift settles
			if (auto_commutation_mode && !sc && (zc_hw || shr || shl))
				mul_pending_q <= 1'b1; // recompute after shift
			else if (auto_commutation_mode && !sc && mul_pending_q) begin
				commutation_compare_q <= mul_res;
				mul_pending_q <= 1'b0;
			end else if (hw_match &&
				commutation_compare_q < delay_timer_q)
				commutation_compare_q <= delay_timer_q; // late result
			else if (shr)
				commutation_compare_q <= commutation_compare_q >> 1;
			else if (shl)
				commutation_compare_q <= commutation_compare_q << 1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// prescaler and ratio: counter held at zero while the clock enable is off
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		divider_ratio_q <= {RATIO_W{1'b0}};
		presc_cnt_q <= 16'h0000;
	end else begin
		presc_cnt_q <= (!cke || tick) ? 16'h0000 : presc_cnt_q + 16'h0001;
		if (!cke && wr && paddr == `ADDR_DIVIDER)
			divider_ratio_q <= pwdata[RATIO_W-1:0];
		else if (shr)
			divider_ratio_q <= divider_ratio_q + 1'b1;
		else if (shl)
			divider_ratio_q <= divider_ratio_q - 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////
// demag capture: stamps the running timer and shifts with the others
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		demag_register_q <= `RST_BYTE;
	end else begin
		if (wr_demag)
			demag_register_q <= pwdata[7:0];
		else if (dm_evt && cke)
			demag_register_q <= delay_timer_q;
		else if (shr)
			demag_register_q <= demag_register_q >> 1;
		else if (shl)
			demag_register_q <= demag_register_q << 1;
	end
end

////////////////////////////////////////////////////////////////////////////
// flags
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		commutation_flag_q <= 1'b0;
		commutation_irq_mask_q <= 1'b0;
		ratio_up_request_q <= 1'b0;
		ratio_down_request_q <= 1'b0;
		overflow_flag_q <= 1'b0;
		control_reg_c_q <= 4'h0;
		tacho_edge_select_q <= 2'h0;
		phase_weight_q <= `RST_BYTE;
		commutation_event <= 1'b0;
		preload_strobe <= 1'b0;
	end else begin
		commutation_event <= commute;
		preload_strobe <= commute;
		if (wr && paddr == `ADDR_CTRL)
			control_reg_c_q <= pwdata[3:0];
		if (wr && paddr == `ADDR_PARAM)
			tacho_edge_select_q <= pwdata[`PAR_TES_LSB+1:`PAR_TES_LSB];
		if (wr && paddr == `ADDR_WEIGHT)
			phase_weight_q <= pwdata[7:0];
		if (wr_flags) begin
			commutation_irq_mask_q <= pwdata[`FLG_CIM];
			commutation_flag_q <= pwdata[`FLG_CI];
			overflow_flag_q <= pwdata[`FLG_OI];
			// both requests at once would allow two updates in one step
			if (!(pwdata[`FLG_RPI] && pwdata[`FLG_RMI])) begin
				ratio_up_request_q <= pwdata[`FLG_RPI];
				ratio_down_request_q <= pwdata[`FLG_RMI];
			end
		end
		// hardware sets follow the software write, so a same-cycle event wins
		if (commute)
			commutation_flag_q <= 1'b1;
		if (commute && !auto_commutation_mode) begin
			ratio_up_request_q <= 1'b0;
			ratio_down_request_q <= 1'b0;
		end
		if (auto_up)
			ratio_up_request_q <= 1'b1;
		if (auto_dn)
			ratio_down_request_q <= 1'b1;
		if (at_max && six_step && (!auto_commutation_mode || divider_ratio_q == `RATIO_MAX
			|| auto_up))
			overflow_flag_q <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////
// read mux
// unmapped offsets read zero; writes to them are dropped
always @* begin
	prdata = 32'h00000000;
	case (paddr)
	`ADDR_TIMER: prdata[7:0] = delay_timer_q;
	`ADDR_COMPARE: prdata[7:0] = commutation_compare_q;
	`ADDR_DEMAG: prdata[7:0] = demag_register_q;
	`ADDR_ZLATEST: prdata[7:0] = zero_cross_latest_q;
	`ADDR_ZPRIOR: prdata[7:0] = zero_cross_prior_q;
	`ADDR_WEIGHT: prdata[7:0] = phase_weight_q;
	`ADDR_DIVIDER: prdata[RATIO_W-1:0] = divider_ratio_q;
	`ADDR_CTRL: prdata[3:0] = control_reg_c_q;
	`ADDR_PARAM: prdata[1:0] = tacho_edge_select_q;
	`ADDR_FLAGS: prdata[4:0] = {overflow_flag_q, ratio_down_request_q,
		ratio_up_request_q, commutation_irq_mask_q, commutation_flag_q};
	default: prdata = 32'h00000000;
	endcase
end

endmodule

// ### dv/delay_manager_monitor.sv
// port checker for the delay manager
`timescale 1ns/1ps
`include "delay_manager_map.vh"
module delay_manager_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire commutation_event,
	input wire preload_strobe,
	input wire commutation_irq,
	input wire speed_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	sequence acc_s;
		psel && penable;
	endsequence
	sequence rd_s;
		acc_s ##0 !pwrite;
	endsequence
	sequence par_wr_s;
		acc_s ##0 pwrite && paddr == `ADDR_PARAM;
	endsequence
	a_ready_always: assert property (psel |-> pready)
		else $error("pready low in a transfer");
	a_no_slave_error: assert property (psel |-> !pslverr)
		else $error("pslverr raised");
	a_preload_paired: assert property (preload_strobe == commutation_event)
		else $error("preload strobe not paired with commutation");
	a_speed_follows: assert property (par_wr_s |=>
		speed_mode == ($past(pwdata[1:0]) != 2'h0))
		else $error("speed mode does not follow tacho select");
	a_speed_held: assert property ($changed(speed_mode) |->
		$past(psel && penable && pwrite && paddr == `ADDR_PARAM))
		else $error("speed mode changed without a write");
	a_upper_zero: assert property (rd_s |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property (rd_s ##0 paddr > `ADDR_FLAGS
		|-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_irq_cause: assert property ($rose(commutation_irq) |->
		commutation_event || $past(commutation_event) ||
		$past(psel && penable && pwrite && paddr == `ADDR_FLAGS))
		else $error("interrupt rose without a commutation");
endmodule

// ### dv/detect_model.sv
// stand-in for the input detection block: event levels on command
`timescale 1ns/1ps
module detect_model (
	input wire pclk,
	input wire fire_zc,
	input wire fire_dm,
	output wire zero_cross_in,
	output wire demag_in
);
	reg [2:0] zc_q = 3'h0;
	reg [2:0] dm_q = 3'h0;
	// levels held four cycles so the two-stage synchroniser sees them
	always @(posedge pclk) begin
		zc_q <= fire_zc ? 3'h4 : (zc_q != 3'h0 ? zc_q - 3'h1 : 3'h0);
		dm_q <= fire_dm ? 3'h4 : (dm_q != 3'h0 ? dm_q - 3'h1 : 3'h0);
	end
	assign zero_cross_in = zc_q != 3'h0;
	assign demag_in = dm_q != 3'h0;
endmodule

// ### dv/delay_manager_bench.sv
// self-checking bench for the delay manager
`timescale 1ns/1ps
`include "delay_manager_map.vh"
module delay_manager_bench;
	reg pclk, presetn, psel, penable, pwrite, fire_zc, fire_dm;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, zero_cross_in, demag_in, commutation_event;
	wire preload_strobe, commutation_irq, speed_mode;
	integer failures, comparisons, i, n;
	typedef struct packed {logic [11:0] a; logic [7:0] d, e; logic s;} row_t;
	row_t rows [0:8];
	delay_manager u_delay_manager (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .zero_cross_in(zero_cross_in),
		.demag_in(demag_in), .commutation_event(commutation_event),
		.preload_strobe(preload_strobe),
		.commutation_irq(commutation_irq), .speed_mode(speed_mode));
	detect_model u_detect_model (.pclk(pclk), .fire_zc(fire_zc),
		.fire_dm(fire_dm), .zero_cross_in(zero_cross_in),
		.demag_in(demag_in));
	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		begin
			if (failures == 0 && comparisons > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask
	task check8(input string what, input [7:0] exp, input [7:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("ERROR %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// one access, held until pready is seen high, then an idle cycle
	task apb(input [11:0] a, input w, input [7:0] d);
		begin
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= {24'h000000, d};
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 50) begin
				n = n + 1;
				@(posedge pclk);
			end
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			if (n == 50) begin
				failures = failures + 1;
				tally_and_finish;
			end
			@(posedge pclk);
		end
	endtask
	task rchk(input string what, input [11:0] a, input [7:0] e);
		begin
			apb(a, 1'b0, 8'h00);
			check8(what, e, rd[7:0]);
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		failures = 0;
		comparisons = 0;
		{presetn, psel, penable, pwrite, fire_zc, fire_dm} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		rows[0] = '{`ADDR_COMPARE, 8'h5A, 8'h5A, 1'b0};
		rows[1] = '{`ADDR_DEMAG, 8'h3C, 8'h3C, 1'b0};
		rows[2] = '{`ADDR_WEIGHT, 8'hC3, 8'hC3, 1'b0};
		rows[3] = '{`ADDR_DIVIDER, 8'h0F, 8'h0F, 1'b0};
		rows[4] = '{`ADDR_PARAM, 8'h01, 8'h01, 1'b1};
		rows[5] = '{`ADDR_PARAM, 8'h02, 8'h02, 1'b1};
		rows[6] = '{`ADDR_PARAM, 8'h03, 8'h03, 1'b1};
		rows[7] = '{`ADDR_PARAM, 8'h00, 8'h00, 1'b0};
		rows[8] = '{12'h030, 8'hA5, 8'h00, 1'b0};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 10; i = i + 1) rchk("reset", 12'(i * 4), `RST_BYTE);
		for (i = 0; i < 9; i = i + 1) begin
			apb(rows[i].a, 1'b1, rows[i].d);
			rchk("row", rows[i].a, rows[i].e);
			check8("speed_mode", {7'h0, rows[i].s}, {7'h0, speed_mode});
		end
		apb(`ADDR_DIVIDER, 1'b1, 8'h00);
		apb(`ADDR_COMPARE, 1'b1, 8'h40);
		apb(`ADDR_FLAGS, 1'b1, 8'h06);
		apb(`ADDR_CTRL, 1'b1, 8'h01);
		apb(`ADDR_DIVIDER, 1'b1, 8'h07);
		n = 0;
		while (commutation_event !== 1'b1 && n < 2000) begin
			n = n + 1;
			@(posedge pclk);
		end
		if (n == 2000) begin
			failures = failures + 1;
			tally_and_finish;
		end
		check8("event", 8'h01, {7'h0, commutation_event});
		@(posedge pclk);
		check8("irq", 8'h01, {7'h0, commutation_irq});
		apb(`ADDR_CTRL, 1'b1, 8'h00);
		rchk("flags", `ADDR_FLAGS, 8'h03);
		rchk("ratio", `ADDR_DIVIDER, 8'h01);
		rchk("compare", `ADDR_COMPARE, 8'h20);
		apb(`ADDR_FLAGS, 1'b1, 8'h0A);
		apb(`ADDR_FLAGS, 1'b1, 8'h0E);
		rchk("requests", `ADDR_FLAGS, 8'h0A);
		check8("irq", 8'h00, {7'h0, commutation_irq});
		apb(`ADDR_DIVIDER, 1'b1, 8'h0F);
		apb(`ADDR_TIMER, 1'b1, 8'h33);
		apb(`ADDR_CTRL, 1'b1, 8'h01);
		fire_zc <= 1'b1;
		fire_dm <= 1'b1;
		@(posedge pclk);
		fire_zc <= 1'b0;
		fire_dm <= 1'b0;
		repeat (12) @(posedge pclk);
		rchk("timer", `ADDR_TIMER, 8'h33);
		rchk("demag", `ADDR_DEMAG, 8'h33);
		apb(`ADDR_CTRL, 1'b1, 8'h00);
		tally_and_finish;
	end
endmodule
bind delay_manager delay_manager_monitor u_delay_manager_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.commutation_event(commutation_event), .preload_strobe(preload_strobe),
	.commutation_irq(commutation_irq), .speed_mode(speed_mode));
